// File: src/fcd_pkg.sv
// Package for the four-channel DMA addressing block
package fcd_pkg;
    localparam int NUM_CHAN = 4;
    localparam int ADDR_W = 26;
    localparam int HALF_W = 16;
    localparam int CNT_W = 16;
    // Register offsets within a channel, channel stride 0x20 bytes
    localparam logic [7:0] OFF_SRC_HIGH = 8'h00;
    localparam logic [7:0] OFF_SRC_LOW = 8'h04;
    localparam logic [7:0] OFF_DST_HIGH = 8'h08;
    localparam logic [7:0] OFF_DST_LOW = 8'h0c;
    localparam logic [7:0] OFF_COUNT = 8'h10;
    localparam logic [7:0] OFF_CTRL = 8'h14;
    localparam int CHAN_SHIFT = 5;
    // Global registers
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h80;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h84;
    localparam logic [7:0] OFF_SW_TRIGGER = 8'h88;
    // Control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_INIT_BIT = 1;
    localparam int CTRL_SIZE16_BIT = 2;
    localparam int CTRL_TC_BIT = 7;
    localparam int CTRL_SRCDIR_LSB = 8;
    localparam int CTRL_DSTDIR_LSB = 10;
    localparam int CTRL_REQSEL_LSB = 12;
    localparam int DST_SPACE_BIT = 15;
    localparam int HIGH_ADDR_LSB = 0;
    localparam int HIGH_ADDR_W = 10;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

    typedef enum logic [1:0] {FCD_DIR_INC, FCD_DIR_DEC, FCD_DIR_FIX, FCD_DIR_BAD} fcd_dir_t;
    typedef enum logic [1:0] {FCD_REQ_PERIPH, FCD_REQ_PIN, FCD_REQ_SW, FCD_REQ_NONE} fcd_reqsel_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } fcd_bus_req_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic size16;
        logic dst_space;
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
    } fcd_mem_req_t;
endpackage : fcd_pkg

// File: src/fcd_sync.sv
// Two-stage synchroniser for pin-level request inputs
`timescale 1ns/1ps
`default_nettype none
module fcd_sync #(
    parameter int WIDTH = 4
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : fcd_sync
`default_nettype wire

// File: src/fcd_addr_step.sv
// Next-address calculation for one side of a transfer
`timescale 1ns/1ps
`default_nettype none
module fcd_addr_step (
    input wire logic [fcd_pkg::ADDR_W-1:0] addr,
    input wire fcd_pkg::fcd_dir_t dir,
    input wire logic size16,
    output logic [fcd_pkg::ADDR_W-1:0] next_addr
);
    logic [fcd_pkg::ADDR_W-1:0] step;
    always_comb begin
        step = size16 ? fcd_pkg::ADDR_W'(2) : fcd_pkg::ADDR_W'(1);
        unique case (dir)
            fcd_pkg::FCD_DIR_INC: next_addr = addr + step;
            fcd_pkg::FCD_DIR_DEC: next_addr = addr - step;
            default: next_addr = addr;
        endcase
    end
endmodule : fcd_addr_step
`default_nettype wire

// File: src/fcd_dma.sv
// Four-channel DMA addressing controller with Avalon-MM slave
// Function
// - Four channels run independently, each with its own addresses and control
// - Each channel moves 8-bit or 16-bit units as configured
// - One programming allows up to 65,536 transfers
// - Each request moves one unit: source read, then destination write
// - Requests come from peripheral interrupts, external pins or software trigger
// - Any pairing of RAM, external memory and peripheral is allowed
// - 26-bit source address in two 16-bit halves, 16-bit access
// - 26-bit destination address in two 16-bit halves, 16-bit access
// - Destination space bit: 0 external or peripheral, 1 internal RAM
// - During a sequence the registers show the next transfer address
// - On completion the registers return to the programmed address
// - Two separate 16-bit reads, no snapshot of the full address
// - Completion flag sets on last transfer, clears on read
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fcd_dma #(
    parameter int NCH = fcd_pkg::NUM_CHAN
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [NCH-1:0] PERIPH_REQ,
    input wire logic [NCH-1:0] PIN_REQ,
    output var fcd_pkg::fcd_mem_req_t MEM_REQ,
    input wire logic MEM_DONE,
    input wire logic [15:0] MEM_RDATA,
    output logic IRQ
);
    localparam int W = fcd_pkg::ADDR_W;
    typedef enum logic [1:0] {FCD_IDLE, FCD_READ, FCD_WRITE} fcd_state_t;

    fcd_pkg::fcd_bus_req_t bus;
    logic [W-1:0] src_reg [NCH];
    logic [W-1:0] dst_reg [NCH];
    logic [W-1:0] src_prog_reg [NCH];
    logic [W-1:0] dst_prog_reg [NCH];
    logic [NCH-1:0] dsel_reg;
    logic [15:0] cnt_reg [NCH];
    logic [15:0] cnt_prog_reg [NCH];
    logic [15:0] ctrl_reg [NCH];
    logic [NCH-1:0] tc_reg;
    logic [NCH-1:0] pend_reg;
    logic [NCH-1:0] sts_reg;
    logic [NCH-1:0] mask_reg;
    logic [NCH-1:0] pin_sync;
    logic [NCH-1:0] pin_prev_reg;
    logic [NCH-1:0] periph_prev_reg;
    logic [NCH-1:0] sw_trig;
    logic [NCH-1:0] hw_req;
    fcd_state_t state_reg;
    logic [1:0] chan_reg;
    logic [15:0] data_reg;
    logic acc_done_reg;
    logic [W-1:0] src_next;
    logic [W-1:0] dst_next;
    logic [1:0] rch;
    logic [7:0] roff;
    logic in_chan;
    logic last;
    logic finish;
    logic [NCH-1:0] tc_read;

    function automatic logic [1:0] chan_of(input logic [7:0] a);
        chan_of = a[fcd_pkg::CHAN_SHIFT +: 2];
    endfunction : chan_of

    function automatic logic [7:0] off_of(input logic [7:0] a);
        off_of = {3'h0, a[fcd_pkg::CHAN_SHIFT-1:0]};
    endfunction : off_of

    assign bus = '{read: AVS_READ, write: AVS_WRITE, address: AVS_ADDRESS,
                   writedata: AVS_WRITEDATA};
    assign rch = chan_of(bus.address);
    assign roff = off_of(bus.address);
    assign in_chan = bus.address < 8'h80;
    // One wait cycle on every access, then the answer
    assign AVS_WAITREQUEST = (bus.read | bus.write) & ~acc_done_reg;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            acc_done_reg <= 1'b0;
        end else begin
            acc_done_reg <= (bus.read | bus.write) & ~acc_done_reg;
        end
    end

    fcd_sync #(.WIDTH(NCH)) u_pin_sync (
        .CLK_SYS(CLK_SYS),
        .RST(RST),
        .d(PIN_REQ),
        .q(pin_sync)
    );

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pin_prev_reg <= '0;
            periph_prev_reg <= '0;
        end else begin
            pin_prev_reg <= pin_sync;
            periph_prev_reg <= PERIPH_REQ;
        end
    end

    // Request source select per channel and software trigger
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            sw_trig[i] = bus.write & acc_done_reg & (bus.address == fcd_pkg::OFF_SW_TRIGGER)
                         & bus.writedata[i];
            unique case (fcd_pkg::fcd_reqsel_t'(ctrl_reg[i][fcd_pkg::CTRL_REQSEL_LSB +: 2]))
                fcd_pkg::FCD_REQ_PERIPH: hw_req[i] = PERIPH_REQ[i] & ~periph_prev_reg[i];
                fcd_pkg::FCD_REQ_PIN: hw_req[i] = pin_sync[i] & ~pin_prev_reg[i];
                fcd_pkg::FCD_REQ_SW: hw_req[i] = sw_trig[i];
                default: hw_req[i] = 1'b0;
            endcase
        end
    end

    fcd_addr_step u_src_step (
        .addr(src_reg[chan_reg]),
        .dir(fcd_pkg::fcd_dir_t'(ctrl_reg[chan_reg][fcd_pkg::CTRL_SRCDIR_LSB +: 2])),
        .size16(ctrl_reg[chan_reg][fcd_pkg::CTRL_SIZE16_BIT]),
        .next_addr(src_next)
    );

    fcd_addr_step u_dst_step (
        .addr(dst_reg[chan_reg]),
        .dir(fcd_pkg::fcd_dir_t'(ctrl_reg[chan_reg][fcd_pkg::CTRL_DSTDIR_LSB +: 2])),
        .size16(ctrl_reg[chan_reg][fcd_pkg::CTRL_SIZE16_BIT]),
        .next_addr(dst_next)
    );

    assign last = cnt_reg[chan_reg] == 16'h0000;
    assign finish = (state_reg == FCD_WRITE) & MEM_DONE;

    // Read of control clears completion flag
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            tc_read[i] = bus.read & acc_done_reg & in_chan & (rch == 2'(i))
                         & (roff == fcd_pkg::OFF_CTRL);
        end
    end

    // Transfer engine: one unit per request, read then write
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_reg <= FCD_IDLE;
            chan_reg <= 2'h0;
            data_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                FCD_IDLE: begin
                    for (int i = NCH - 1; i >= 0; i--) begin
                        if (pend_reg[i]) begin
                            chan_reg <= 2'(i);
                            state_reg <= FCD_READ;
                        end
                    end
                end
                FCD_READ: begin
                    if (MEM_DONE) begin
                        data_reg <= MEM_RDATA;
                        state_reg <= FCD_WRITE;
                    end
                end
                FCD_WRITE: begin
                    if (MEM_DONE) begin
                        state_reg <= FCD_IDLE;
                    end
                end
                default: state_reg <= FCD_IDLE;
            endcase
        end
    end

    always_comb begin
        MEM_REQ.rd = state_reg == FCD_READ;
        MEM_REQ.wr = state_reg == FCD_WRITE;
        MEM_REQ.size16 = ctrl_reg[chan_reg][fcd_pkg::CTRL_SIZE16_BIT];
        MEM_REQ.dst_space = (state_reg == FCD_WRITE) & dsel_reg[chan_reg];
        MEM_REQ.addr = (state_reg == FCD_WRITE) ? dst_reg[chan_reg] : src_reg[chan_reg];
        MEM_REQ.wdata = data_reg;
    end

    // Per-channel pending requests, addresses, counts and control
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pend_reg <= '0;
            tc_reg <= '0;
            dsel_reg <= '0;
            for (int i = 0; i < NCH; i++) begin
                src_reg[i] <= '0;
                dst_reg[i] <= '0;
                src_prog_reg[i] <= '0;
                dst_prog_reg[i] <= '0;
                cnt_reg[i] <= 16'h0000;
                cnt_prog_reg[i] <= 16'h0000;
                ctrl_reg[i] <= fcd_pkg::CTRL_RESET;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (tc_read[i]) begin
                    tc_reg[i] <= 1'b0;
                end
                if (hw_req[i] & ctrl_reg[i][fcd_pkg::CTRL_ENABLE_BIT] & ~tc_reg[i]) begin
                    pend_reg[i] <= 1'b1;
                end
            end
            if (state_reg == FCD_IDLE) begin
                for (int i = 0; i < NCH; i++) begin
                    // Only the granted lowest channel drops its request
                    if (pend_reg[i] && ((pend_reg & ((NCH'(1) << i) - NCH'(1))) == '0)) begin
                        pend_reg[i] <= 1'b0;
                    end
                end
            end
            if (finish) begin
                if (last) begin
                    src_reg[chan_reg] <= src_prog_reg[chan_reg];
                    dst_reg[chan_reg] <= dst_prog_reg[chan_reg];
                    cnt_reg[chan_reg] <= cnt_prog_reg[chan_reg];
                    tc_reg[chan_reg] <= 1'b1;
                end else begin
                    src_reg[chan_reg] <= src_next;
                    dst_reg[chan_reg] <= dst_next;
                    cnt_reg[chan_reg] <= cnt_reg[chan_reg] - 16'h0001;
                end
            end
            if (bus.write & acc_done_reg & in_chan) begin
                unique case (roff)
                    fcd_pkg::OFF_SRC_HIGH: begin
                        src_reg[rch][W-1:16] <= bus.writedata[9:0];
                        src_prog_reg[rch][W-1:16] <= bus.writedata[9:0];
                    end
                    fcd_pkg::OFF_SRC_LOW: begin
                        src_reg[rch][15:0] <= bus.writedata[15:0];
                        src_prog_reg[rch][15:0] <= bus.writedata[15:0];
                    end
                    fcd_pkg::OFF_DST_HIGH: begin
                        dst_reg[rch][W-1:16] <= bus.writedata[9:0];
                        dst_prog_reg[rch][W-1:16] <= bus.writedata[9:0];
                        dsel_reg[rch] <= bus.writedata[fcd_pkg::DST_SPACE_BIT];
                    end
                    fcd_pkg::OFF_DST_LOW: begin
                        dst_reg[rch][15:0] <= bus.writedata[15:0];
                        dst_prog_reg[rch][15:0] <= bus.writedata[15:0];
                    end
                    fcd_pkg::OFF_COUNT: begin
                        cnt_reg[rch] <= bus.writedata[15:0];
                        cnt_prog_reg[rch] <= bus.writedata[15:0];
                    end
                    fcd_pkg::OFF_CTRL: begin
                        ctrl_reg[rch] <= {bus.writedata[15:3], 1'b0, 1'b0,
                                          bus.writedata[fcd_pkg::CTRL_ENABLE_BIT]};
                        ctrl_reg[rch][fcd_pkg::CTRL_SIZE16_BIT] <=
                            bus.writedata[fcd_pkg::CTRL_SIZE16_BIT];
                        if (bus.writedata[fcd_pkg::CTRL_INIT_BIT] &
                            ~bus.writedata[fcd_pkg::CTRL_ENABLE_BIT]) begin
                            pend_reg[rch] <= 1'b0;
                            tc_reg[rch] <= 1'b0;
                            src_reg[rch] <= src_prog_reg[rch];
                            dst_reg[rch] <= dst_prog_reg[rch];
                            cnt_reg[rch] <= cnt_prog_reg[rch];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Interrupt status: completion sets, write-one clears, set wins
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sts_reg <= '0;
            mask_reg <= fcd_pkg::MASK_RESET;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (finish & last & (chan_reg == 2'(i))) begin
                    sts_reg[i] <= 1'b1;
                end else if (bus.write & acc_done_reg &
                             (bus.address == fcd_pkg::OFF_IRQ_STATUS) & bus.writedata[i]) begin
                    sts_reg[i] <= 1'b0;
                end
            end
            if (bus.write & acc_done_reg & (bus.address == fcd_pkg::OFF_IRQ_MASK)) begin
                mask_reg <= bus.writedata[NCH-1:0];
            end
        end
    end

    assign IRQ = |(sts_reg & mask_reg);

    // Read data, one half per access, no snapshot
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            AVS_READDATA <= 32'h00000000;
        end else if (bus.read & ~acc_done_reg) begin
            AVS_READDATA <= fcd_pkg::UNMAPPED_READ;
            if (in_chan) begin
                unique case (roff)
                    fcd_pkg::OFF_SRC_HIGH: AVS_READDATA <= {22'h0, src_reg[rch][W-1:16]};
                    fcd_pkg::OFF_SRC_LOW: AVS_READDATA <= {16'h0, src_reg[rch][15:0]};
                    fcd_pkg::OFF_DST_HIGH: AVS_READDATA <= {16'h0, dsel_reg[rch], 5'h0,
                                                            dst_reg[rch][W-1:16]};
                    fcd_pkg::OFF_DST_LOW: AVS_READDATA <= {16'h0, dst_reg[rch][15:0]};
                    fcd_pkg::OFF_COUNT: AVS_READDATA <= {16'h0, cnt_reg[rch]};
                    fcd_pkg::OFF_CTRL: AVS_READDATA <= {16'h0, ctrl_reg[rch][15:8],
                                                        tc_reg[rch], 4'h0,
                                                        ctrl_reg[rch][2], 2'h0};
                    default: ;
                endcase
            end else if (bus.address == fcd_pkg::OFF_IRQ_STATUS) begin
                AVS_READDATA <= {28'h0, sts_reg};
            end else if (bus.address == fcd_pkg::OFF_IRQ_MASK) begin
                AVS_READDATA <= {28'h0, mask_reg};
            end
        end
    end

    AST_ONE_UNIT_TWO_CYCLES: assert property (@(posedge CLK_SYS) disable iff (RST)
        (state_reg == FCD_READ && MEM_DONE) |=> MEM_REQ.wr)
        else $error("read not followed by write");
    AST_TC_ON_LAST: assert property (@(posedge CLK_SYS) disable iff (RST)
        (finish && last) |=> tc_reg[$past(chan_reg)])
        else $error("completion flag not set");
    AST_RESTORE_DST: assert property (@(posedge CLK_SYS) disable iff (RST)
        (finish && last && !(bus.write && acc_done_reg))
        |=> dst_reg[$past(chan_reg)] == $past(dst_prog_reg[chan_reg]))
        else $error("destination not restored");
    AST_RESTORE_SRC: assert property (@(posedge CLK_SYS) disable iff (RST)
        (finish && last && !(bus.write && acc_done_reg))
        |=> src_reg[$past(chan_reg)] == $past(src_prog_reg[chan_reg]))
        else $error("source not restored");
    AST_NEXT_DST: assert property (@(posedge CLK_SYS) disable iff (RST)
        (finish && !last && !(bus.write && acc_done_reg))
        |=> dst_reg[$past(chan_reg)] == $past(dst_next))
        else $error("destination did not advance");
    AST_SIZE_OUT: assert property (@(posedge CLK_SYS) disable iff (RST)
        (finish && !last && !(bus.write && acc_done_reg) && MEM_REQ.size16
         && ctrl_reg[chan_reg][fcd_pkg::CTRL_DSTDIR_LSB +: 2] == 2'h0)
        |=> dst_reg[$past(chan_reg)] == $past(MEM_REQ.addr) + 26'h2)
        else $error("16-bit unit did not step by two");
    AST_SPACE_SEL: assert property (@(posedge CLK_SYS) disable iff (RST)
        MEM_REQ.wr |-> MEM_REQ.dst_space == dsel_reg[chan_reg])
        else $error("destination space wrong");
    AST_WAIT_ONE: assert property (@(posedge CLK_SYS) disable iff (RST)
        $rose(AVS_READ | AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("bus answer timing wrong");
    AST_TC_CLEAR: assert property (@(posedge CLK_SYS) disable iff (RST)
        (tc_read[0] && !(finish && last && chan_reg == 2'h0)) |=> !tc_reg[0])
        else $error("completion flag not cleared");
    COV_TRANSFER: cover property (@(posedge CLK_SYS) disable iff (RST) finish);
    COV_COMPLETE: cover property (@(posedge CLK_SYS) disable iff (RST) finish && last);
    COV_IRQ: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(IRQ));
endmodule : fcd_dma
`default_nettype wire

// File: tb/fcd_mem_model.sv
// Memory and peripheral side model answering the transfer engine
`timescale 1ns/1ps
`default_nettype none
module fcd_mem_model (
    input wire logic CLK_SYS,
    input wire fcd_pkg::fcd_mem_req_t req,
    input wire logic [7:0] dly,
    output logic done,
    output logic [15:0] rdata,
    output int n_rd,
    output int n_wr,
    output logic [25:0] wr_addr,
    output logic [15:0] wr_data,
    output logic [1:0] wr_flags
);
    initial begin
        done = 1'b0;
        rdata = 16'h0000;
        n_rd = 0;
        n_wr = 0;
        forever begin
            @(posedge CLK_SYS);
            if (req.rd || req.wr) begin
                repeat (dly) @(posedge CLK_SYS);
                done <= 1'b1;
                if (req.rd) begin
                    rdata <= req.addr[15:0] ^ 16'ha5a5;
                    n_rd <= n_rd + 1;
                end else begin
                    wr_addr <= req.addr;
                    wr_data <= req.wdata;
                    wr_flags <= {req.dst_space, req.size16};
                    n_wr <= n_wr + 1;
                end
                @(posedge CLK_SYS);
                done <= 1'b0;
                // Released data lines do not keep the last value
                rdata <= ~rdata;
            end
        end
    end
endmodule : fcd_mem_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the four-channel transfer engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic mem_done;
    logic [3:0] periph_req = 4'h0;
    logic [3:0] pin_req = 4'h0;
    fcd_pkg::fcd_mem_req_t mem_req;
    logic [15:0] mem_rdata;
    logic [7:0] dly = 8'h00;
    int n_rd;
    int n_wr;
    int num_errors = 0;
    int samples_checked = 0;
    logic [25:0] wr_addr;
    logic [15:0] wr_data;
    logic [1:0] wr_flags;
    logic [31:0] rd;
    logic [7:0] b;

    always #5 clk_sys = ~clk_sys;

    fcd_dma dut (.CLK_SYS(clk_sys), .RST(rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .PERIPH_REQ(periph_req), .PIN_REQ(pin_req),
        .MEM_REQ(mem_req), .MEM_DONE(mem_done), .MEM_RDATA(mem_rdata), .IRQ(irq));
    fcd_mem_model mem (.CLK_SYS(clk_sys), .req(mem_req), .dly(dly), .done(mem_done),
        .rdata(mem_rdata), .n_rd(n_rd), .n_wr(n_wr), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_flags(wr_flags));

    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", name, exp, got);
        end
    endtask : chk

    task automatic wait_ack;
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 50) begin
            chk("bus ack", 32'h0, 32'h1);
            stop_test();
        end
    endtask : wait_ack

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_write <= 1'b1;
        avs_address <= a;
        avs_writedata <= d;
        wait_ack();
        avs_write <= 1'b0;
    endtask : bus_wr

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        avs_read <= 1'b1;
        avs_address <= a;
        wait_ack();
        rd = avs_readdata;
        avs_read <= 1'b0;
        chk(name, exp, rd);
    endtask : rd_chk

    task automatic wait_cnt(input int nr, input int nw);
        int i;
        for (i = 0; i < 500 && !(n_rd >= nr && n_wr >= nw); i++) @(posedge clk_sys);
        if (i == 500) begin
            chk("transfer wait", 32'h0, 32'h1);
            stop_test();
        end
    endtask : wait_cnt

    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk("ctrl reset", fcd_pkg::OFF_CTRL, {16'h0000, fcd_pkg::CTRL_RESET});
        rd_chk("mask reset", fcd_pkg::OFF_IRQ_MASK, {28'h0, fcd_pkg::MASK_RESET});
        rd_chk("unmapped", 8'hfc, fcd_pkg::UNMAPPED_READ);
        chk("irq reset", 32'h0, {31'h0, irq});
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            b = 8'(c * 32);
            bus_wr(b + fcd_pkg::OFF_SRC_HIGH, 32'h0100 + c);
            bus_wr(b + fcd_pkg::OFF_SRC_LOW, 32'h4000 + c);
            bus_wr(b + fcd_pkg::OFF_DST_HIGH, 32'h8200 + c);
            bus_wr(b + fcd_pkg::OFF_DST_LOW, 32'hc000 + c);
            bus_wr(b + fcd_pkg::OFF_COUNT, (c == 3) ? 32'hffff : 32'h0);
        end
        for (int c = 0; c < 4; c++) begin
            b = 8'(c * 32);
            rd_chk("src high", b + fcd_pkg::OFF_SRC_HIGH, 32'h0100 + c);
            rd_chk("src low", b + fcd_pkg::OFF_SRC_LOW, 32'h4000 + c);
            rd_chk("dst high", b + fcd_pkg::OFF_DST_HIGH, 32'h8200 + c);
            rd_chk("dst low", b + fcd_pkg::OFF_DST_LOW, 32'hc000 + c);
        end
        rd_chk("max count", 8'h60 + fcd_pkg::OFF_COUNT, 32'hffff);
        $display("test registers done");
        // Channel 1: two 16-bit software transfers against a slow far side
        dly <= 8'd20;
        bus_wr(8'h20 + fcd_pkg::OFF_SRC_HIGH, 32'h0012);
        bus_wr(8'h20 + fcd_pkg::OFF_SRC_LOW, 32'h0100);
        bus_wr(8'h20 + fcd_pkg::OFF_DST_HIGH, 32'h8034);
        bus_wr(8'h20 + fcd_pkg::OFF_DST_LOW, 32'h0200);
        bus_wr(8'h20 + fcd_pkg::OFF_COUNT, 32'h0001);
        bus_wr(8'h20 + fcd_pkg::OFF_CTRL, 32'h2005);
        bus_wr(fcd_pkg::OFF_IRQ_MASK, 32'h2);
        bus_wr(fcd_pkg::OFF_SW_TRIGGER, 32'h2);
        wait_cnt(1, 1);
        chk("writes mid", 32'h1, 32'(n_wr));
        rd_chk("dst next", 8'h20 + fcd_pkg::OFF_DST_LOW, 32'h0202);
        rd_chk("src next", 8'h20 + fcd_pkg::OFF_SRC_LOW, 32'h0102);
        bus_wr(fcd_pkg::OFF_SW_TRIGGER, 32'h2);
        wait_cnt(2, 2);
        chk("wr addr", {6'h0, 26'h0340202}, {6'h0, wr_addr});
        chk("wr data", 32'h0102 ^ 32'ha5a5, {16'h0, wr_data});
        chk("wr flags", 32'h3, {30'h0, wr_flags});
        repeat (4) @(posedge clk_sys);
        chk("irq set", 32'h1, {31'h0, irq});
        rd_chk("tc set", 8'h20 + fcd_pkg::OFF_CTRL, 32'h2084);
        rd_chk("tc clear", 8'h20 + fcd_pkg::OFF_CTRL, 32'h2004);
        rd_chk("dst back", 8'h20 + fcd_pkg::OFF_DST_LOW, 32'h0200);
        rd_chk("dst hi back", 8'h20 + fcd_pkg::OFF_DST_HIGH, 32'h8034);
        rd_chk("src back", 8'h20 + fcd_pkg::OFF_SRC_LOW, 32'h0100);
        rd_chk("status", fcd_pkg::OFF_IRQ_STATUS, 32'h2);
        bus_wr(fcd_pkg::OFF_IRQ_STATUS, 32'h2);
        rd_chk("status clr", fcd_pkg::OFF_IRQ_STATUS, 32'h0);
        chk("irq clear", 32'h0, {31'h0, irq});
        $display("test software transfer done");
        // Channel 0: one byte on a peripheral request, status masked
        dly <= 8'd0;
        bus_wr(fcd_pkg::OFF_CTRL, 32'h0001);
        @(posedge clk_sys);
        periph_req <= 4'h1;
        @(posedge clk_sys);
        periph_req <= 4'h0;
        wait_cnt(3, 3);
        chk("p wr addr", {6'h0, 26'h200c000}, {6'h0, wr_addr});
        chk("p wr data", 32'ha5, {24'h0, wr_data[7:0]});
        chk("p wr flags", 32'h2, {30'h0, wr_flags});
        rd_chk("p status", fcd_pkg::OFF_IRQ_STATUS, 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd_chk("p tc", fcd_pkg::OFF_CTRL, 32'h0080);
        rd_chk("p dst back", fcd_pkg::OFF_DST_LOW, 32'hc000);
        $display("test peripheral transfer done");
        // Channel 2: one byte on a pin request
        bus_wr(8'h40 + fcd_pkg::OFF_CTRL, 32'h1001);
        @(posedge clk_sys);
        pin_req <= 4'h4;
        repeat (4) @(posedge clk_sys);
        pin_req <= 4'h0;
        wait_cnt(4, 4);
        chk("n wr addr", {6'h0, 26'h202c002}, {6'h0, wr_addr});
        chk("n wr data", 32'ha7, {24'h0, wr_data[7:0]});
        rd_chk("ch3 intact", 8'h60 + fcd_pkg::OFF_DST_LOW, 32'hc003);
        $display("test pin transfer done");
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
